// [hw/llpc_top.sv]
// LIN pin, receive filter, transmit monitor, pin 8 and LED pad control
// What this block does
// RULE1 - Pin 8 function field picks GPIO, PWM, UART RX, UART single-wire, MOSI, filter output
// RULE2 - In GPIO function, output enable follows controller direction; pad options come from register
// RULE3 - Pin 8 pull-up bit is active low and resets to one
// RULE4 - Read-enable bit gates the pin 8 input path to logic
// RULE5 - LIN owner bit: zero gives pin to port B bit one, one to responder
// RULE6 - Policy zero forces transmit analog off in hibernate unless bus is dominant
// RULE7 - Four filter enable bits, stages one to three and sleep, reset all ones
// RULE8 - Filter enable writes only land after trim key and unlock bit
// RULE9 - Stage one has 7-bit rise and fall counts, resets zero and 0x8
// RULE10 - Stage two counts reset 0x10 falling and 0x20 rising
// RULE11 - Stage three counts both reset 0x28
// RULE12 - Monitor sets stuck flag after transmit data dominant for 64 ms
// RULE13 - Stuck flag clears on dominant to recessive transmit edge, not by software
// RULE14 - Stuck flag disables the LIN transmitter
// RULE15 - Monitor enable bit is read-write and resets to one
// RULE16 - 24 LED source bits: zero manual data, one PWM; no readback of pins
// RULE17 - Manual-sourced LED channels follow the manual data register bit
// RULE18 - LED pull-up bits switch on each channel pull-up
// RULE19 - Software waits about 40 us after sense enable before ADC conversion
// RULE20 - Forward current with ADC channel 2 active drives channel picked by select
// RULE21 - Stuck interrupt has enable, self-clearing clear, status and active bits
// RULE22 - Software sets unlock bit before changing protected filter settings
// RULE23 - Enabled stage passes level after programmed hold count; disabled passes through
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module llpc_top #(
   parameter int TX_STUCK_CYCLES = llpc_pkg::TX_STUCK_CYC_DEF,
   parameter logic [31:0] TRIM_KEY_VALUE = 32'h0000005a
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire llpc_pkg::llpc_bus_req_t bus_req,
   output      logic [31:0]         rdata,
   input  wire logic                pin8_in,
   output      logic                pin8_out,
   output      logic                pin8_oe,
   output      llpc_pkg::llpc_pad_t pin8_pad,
   input  wire logic                port_a_bit_seven_out,
   input  wire logic                port_a_bit_seven_dir,
   output      logic                port_a_bit_seven_in,
   input  wire logic                pwm3_out,
   input  wire logic                uart_txd,
   input  wire logic                uart_tx_oe,
   output      logic                uart_rxd,
   input  wire logic                spi_mosi,
   input  wire logic                lin_pin_in,
   output      logic                lin_pin_out,
   output      logic                lin_pin_oe,
   output      logic                lin_tx_analog_on,
   input  wire logic                hibernate,
   input  wire logic                lin_sleep,
   input  wire logic                port_b_bit_one_out,
   input  wire logic                port_b_bit_one_dir,
   output      logic                port_b_bit_one_in,
   input  wire logic                responder_txd,
   output      logic                responder_rxd,
   input  wire logic [23:0]         pwm_led,
   output      logic [23:0]         led_drive,
   output      logic [23:0]         led_pullup_bits,
   output      logic [23:0]         led_forward_drive,
   output      logic                forward_sense_on,
   input  wire logic                adc_ch2_active,
   input  wire logic [4:0]          channel_two_led_pick
);
   logic [31:0]            pad_reg;
   logic [31:0]            lin_reg;
   logic [3:0]             rx_filter_stage_enables;
   logic [6:0]             stage1_rise_count, stage1_fall_count;
   logic [6:0]             stage2_rise_count, stage2_fall_count;
   logic [6:0]             stage3_rise_count, stage3_fall_count;
   logic                   tx_stuck_watch_on;
   logic                   tx_stuck_flag;
   logic [31:0]            sense_reg;
   logic [23:0]            led_src_reg;
   logic [23:0]            led_manual_drive_bits;
   logic [31:0]            probe_reg;
   logic                   irq_en_reg;
   logic                   irq_clr_reg;
   logic                   irq_sts_reg;
   logic                   filter_write_unlock;
   logic                   trim_open_reg;
   localparam int          STUCK_W = llpc_pkg::STUCK_CNT_W;
   logic [STUCK_W-1:0]     stuck_cnt_reg;
   logic                   txd_prev_reg;
   logic                   flag_prev_reg;
   logic [1:0]             pin8_sync_reg;
   logic [1:0]             lin_sync_reg;
   logic [2:0]             stage_out;
   logic [2:0]             stage_in;
   logic [2:0]             stage_en;
   logic [6:0]             stage_rise [3];
   logic [6:0]             stage_fall [3];
   logic [2:0]             pin8_func;
   logic                   wr;
   logic                   rd;
   logic [31:0]            wdata;
   logic [31:0]            addr;
   logic                   pin8_in_gated;
   logic                   lin_rx_filtered;
   logic                   stuck_hit;
   assign wr = bus_req.wr;
   assign rd = bus_req.rd;
   assign wdata = bus_req.wdata;
   assign addr = bus_req.addr;
   assign pin8_func = pad_reg[2:0];
   assign pin8_in_gated = pin8_sync_reg[1] & pad_reg[5]; // RULE4
   assign lin_rx_filtered = stage_out[2];
   assign stuck_hit = (stuck_cnt_reg >= STUCK_W'(TX_STUCK_CYCLES - 1)) & ~responder_txd & tx_stuck_watch_on;
   // Two-stage synchronisers for pad inputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin8_sync_reg <= 2'h3;
         lin_sync_reg <= 2'h3;
      end else begin
         pin8_sync_reg <= {pin8_sync_reg[0], pin8_in};
         lin_sync_reg <= {lin_sync_reg[0], lin_pin_in};
      end
   end
   // Simple masked registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pad_reg <= llpc_pkg::PIN8_PAD_RST; // RULE3
         lin_reg <= 32'h00000000;
         sense_reg <= llpc_pkg::LED_SENSE_RST;
         led_src_reg <= llpc_pkg::LED_RST;
         led_manual_drive_bits <= llpc_pkg::LED_RST;
         led_pullup_bits <= llpc_pkg::LED_RST;
         probe_reg <= 32'h00000000;
         tx_stuck_watch_on <= 1'b1; // RULE15
         irq_en_reg <= 1'b0;
      end else if (wr) begin
         case (addr)
            llpc_pkg::PIN8_PAD_ADDR: pad_reg <= wdata & llpc_pkg::PIN8_PAD_MASK;
            llpc_pkg::LIN_PIN_ADDR: lin_reg <= {6'h00, wdata[llpc_pkg::POLICY_BIT], 19'h00000,
                                                wdata[llpc_pkg::TXON_BIT], 4'h0, wdata[llpc_pkg::OWNER_BIT]};
            llpc_pkg::LED_SENSE_ADDR: sense_reg <= wdata & llpc_pkg::LED_SENSE_MASK;
            llpc_pkg::LED_SRC_ADDR: led_src_reg <= wdata[23:0]; // RULE16
            llpc_pkg::LED_MAN_ADDR: led_manual_drive_bits <= wdata[23:0]; // RULE17
            llpc_pkg::LED_PU_ADDR: led_pullup_bits <= wdata[23:0]; // RULE18
            llpc_pkg::PROBE_ONE_ADDR: probe_reg <= wdata & llpc_pkg::PROBE_ONE_MASK;
            llpc_pkg::TX_MON_ADDR: tx_stuck_watch_on <= wdata[0]; // RULE15
            llpc_pkg::TX_IRQ_ADDR: irq_en_reg <= wdata[0]; // RULE21
            default: begin
            end
         endcase
      end
   end
   // Filter thresholds
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stage1_rise_count <= llpc_pkg::S1_RISE_RST; // RULE9
         stage1_fall_count <= llpc_pkg::S1_FALL_RST; // RULE9
         stage2_rise_count <= llpc_pkg::S2_RISE_RST; // RULE10
         stage2_fall_count <= llpc_pkg::S2_FALL_RST; // RULE10
         stage3_rise_count <= llpc_pkg::S3_RISE_RST; // RULE11
         stage3_fall_count <= llpc_pkg::S3_FALL_RST; // RULE11
      end else if (wr && addr == llpc_pkg::RXF_S1_ADDR) begin
         stage1_rise_count <= wdata[llpc_pkg::RISE_LO_POS +: 7];
         stage1_fall_count <= wdata[llpc_pkg::FALL_LO_POS +: 7];
      end else if (wr && addr == llpc_pkg::RXF_S23_ADDR) begin
         stage3_rise_count <= wdata[llpc_pkg::S3_RISE_POS +: 7];
         stage3_fall_count <= wdata[llpc_pkg::S3_FALL_POS +: 7];
         stage2_rise_count <= wdata[llpc_pkg::S2_RISE_POS +: 7];
         stage2_fall_count <= wdata[llpc_pkg::S2_FALL_POS +: 7];
      end
   end
   // Protected filter enables, key and unlock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_filter_stage_enables <= llpc_pkg::RXF_EN_RST; // RULE7
         filter_write_unlock <= 1'b0;
         trim_open_reg <= 1'b0;
      end else if (wr) begin
         if (addr == llpc_pkg::TRIM_KEY_ADDR) begin
            trim_open_reg <= (wdata == TRIM_KEY_VALUE);
         end
         if (addr == llpc_pkg::FILT_KEY_ADDR && wdata[llpc_pkg::UNLOCK_BIT]) begin
            filter_write_unlock <= 1'b1; // RULE22
         end
         if (addr == llpc_pkg::RXF_S1_ADDR && trim_open_reg && filter_write_unlock) begin
            rx_filter_stage_enables <= wdata[3:0]; // RULE8
         end
      end
   end
   // Three debounce stages
   assign stage_in = {stage_out[1:0], lin_sync_reg[1]};
   assign stage_en = {lin_sleep ? rx_filter_stage_enables[3] : rx_filter_stage_enables[2],
                      rx_filter_stage_enables[1:0]};
   assign stage_rise = '{stage1_rise_count, stage2_rise_count, stage3_rise_count};
   assign stage_fall = '{stage1_fall_count, stage2_fall_count, stage3_fall_count};
   generate
      for (genvar g = 0; g < 3; g++) begin : g_stage
         logic [6:0] cnt_reg;
         logic       out_reg;
         logic [6:0] thr;
         assign thr = stage_in[g] ? stage_rise[g] : stage_fall[g];
         assign stage_out[g] = out_reg;
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               cnt_reg <= 7'h00;
               out_reg <= 1'b1;
            end else if (!stage_en[g] || stage_in[g] == out_reg) begin
               cnt_reg <= 7'h00;
               out_reg <= stage_in[g]; // RULE23
            end else if (cnt_reg >= thr) begin
               cnt_reg <= 7'h00;
               out_reg <= stage_in[g]; // RULE23
            end else begin
               cnt_reg <= cnt_reg + 7'h01;
            end
         end
      end
   endgenerate
   // Transmit dominant watch
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stuck_cnt_reg <= '0;
         tx_stuck_flag <= 1'b0;
         txd_prev_reg <= 1'b1;
      end else begin
         txd_prev_reg <= responder_txd;
         if (!tx_stuck_watch_on || responder_txd) begin
            stuck_cnt_reg <= '0;
         end else if (!stuck_hit) begin
            stuck_cnt_reg <= stuck_cnt_reg + STUCK_W'(1);
         end
         if (stuck_hit) begin
            tx_stuck_flag <= 1'b1; // RULE12
         end else if (!txd_prev_reg && responder_txd) begin
            tx_stuck_flag <= 1'b0; // RULE13
         end
      end
   end
   // Stuck interrupt bits
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_clr_reg <= 1'b0;
         irq_sts_reg <= 1'b0;
         flag_prev_reg <= 1'b0;
      end else begin
         flag_prev_reg <= tx_stuck_flag;
         irq_clr_reg <= wr && addr == llpc_pkg::TX_IRQ_ADDR && wdata[llpc_pkg::IRQ_CLR_BIT]; // RULE21
         if (tx_stuck_flag && !flag_prev_reg) begin
            irq_sts_reg <= 1'b1; // RULE21
         end else if (irq_clr_reg) begin
            irq_sts_reg <= 1'b0;
         end
      end
   end
   // Pin 8 function mux
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin8_out <= 1'b0;
         pin8_oe <= 1'b0;
         uart_rxd <= 1'b1;
         port_a_bit_seven_in <= 1'b0;
      end else begin
         port_a_bit_seven_in <= (pin8_func == llpc_pkg::FN_GPIO) & pin8_in_gated; // RULE4
         uart_rxd <= 1'b1;
         pin8_out <= 1'b0;
         pin8_oe <= 1'b0;
         case (pin8_func) // RULE1
            llpc_pkg::FN_GPIO: begin
               pin8_out <= port_a_bit_seven_out;
               pin8_oe <= port_a_bit_seven_dir; // RULE2
            end
            llpc_pkg::FN_PWM: begin
               pin8_out <= pwm3_out;
               pin8_oe <= 1'b1;
            end
            llpc_pkg::FN_URX: uart_rxd <= pin8_in_gated | ~pad_reg[5];
            llpc_pkg::FN_USW: begin
               pin8_out <= uart_txd;
               pin8_oe <= uart_tx_oe;
               uart_rxd <= pin8_in_gated | ~pad_reg[5];
            end
            llpc_pkg::FN_MOSI: begin
               pin8_out <= spi_mosi;
               pin8_oe <= 1'b1;
            end
            llpc_pkg::FN_FILT2: begin
               pin8_out <= stage_out[1];
               pin8_oe <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end
   // Pad options straight from register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin8_pad <= llpc_pkg::llpc_pad_t'(llpc_pkg::PIN8_PAD_RST[9:3]);
      end else begin
         pin8_pad <= {pad_reg[9:8], pad_reg[7:3]}; // RULE2
      end
   end
   // LIN pin ownership and transmit power
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lin_pin_out <= 1'b1;
         lin_pin_oe <= 1'b0;
         lin_tx_analog_on <= 1'b0;
         responder_rxd <= 1'b1;
         port_b_bit_one_in <= 1'b1;
      end else begin
         lin_tx_analog_on <= lin_reg[llpc_pkg::TXON_BIT] & ~tx_stuck_flag
            & (lin_reg[llpc_pkg::POLICY_BIT] | ~hibernate | ~lin_sync_reg[1]); // RULE6
         if (lin_reg[llpc_pkg::OWNER_BIT]) begin
            lin_pin_out <= responder_txd; // RULE5
            lin_pin_oe <= lin_reg[llpc_pkg::TXON_BIT] & ~tx_stuck_flag; // RULE14
            responder_rxd <= lin_rx_filtered;
            port_b_bit_one_in <= 1'b1;
         end else begin
            lin_pin_out <= port_b_bit_one_out; // RULE5
            lin_pin_oe <= port_b_bit_one_dir;
            responder_rxd <= 1'b1;
            port_b_bit_one_in <= lin_sync_reg[1];
         end
      end
   end
   // LED drive
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         led_drive <= llpc_pkg::LED_RST;
         led_forward_drive <= llpc_pkg::LED_RST;
         forward_sense_on <= 1'b0;
      end else begin
         led_drive <= (led_src_reg & pwm_led) | (~led_src_reg & led_manual_drive_bits); // RULE16 RULE17
         forward_sense_on <= sense_reg[llpc_pkg::SENSE_BIT];
         if (sense_reg[llpc_pkg::VFW_BIT] && adc_ch2_active && channel_two_led_pick < 5'h18) begin
            led_forward_drive <= 24'h000001 << channel_two_led_pick; // RULE20
         end else begin
            led_forward_drive <= 24'h000000;
         end
      end
   end
   // Read data, one cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         case (addr)
            llpc_pkg::PIN8_PAD_ADDR: rdata <= pad_reg;
            llpc_pkg::LIN_PIN_ADDR: rdata <= lin_reg;
            llpc_pkg::RXF_S1_ADDR: rdata <= {9'h000, stage1_rise_count, 1'b0, stage1_fall_count,
                                             4'h0, rx_filter_stage_enables};
            llpc_pkg::RXF_S23_ADDR: rdata <= {1'b0, stage3_rise_count, 1'b0, stage3_fall_count,
                                              1'b0, stage2_rise_count, 1'b0, stage2_fall_count};
            llpc_pkg::TX_MON_ADDR: rdata <= {23'h000000, tx_stuck_flag, 7'h00, tx_stuck_watch_on};
            llpc_pkg::LED_SENSE_ADDR: rdata <= sense_reg;
            llpc_pkg::LED_SRC_ADDR: rdata <= {8'h00, led_src_reg};
            llpc_pkg::LED_MAN_ADDR: rdata <= {8'h00, led_manual_drive_bits};
            llpc_pkg::LED_PU_ADDR: rdata <= {8'h00, led_pullup_bits};
            llpc_pkg::PROBE_ONE_ADDR: rdata <= probe_reg;
            llpc_pkg::TX_IRQ_ADDR: rdata <= {7'h00, irq_sts_reg & irq_en_reg, 7'h00, irq_sts_reg,
                                             15'h0000, irq_en_reg};
            llpc_pkg::FILT_KEY_ADDR: rdata <= {filter_write_unlock, 31'h00000000};
            llpc_pkg::TRIM_KEY_ADDR: rdata <= {31'h00000000, trim_open_reg};
            default: rdata <= 32'h00000000;
         endcase
      end
   end
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence dom_hold_s;
      tx_stuck_flag && !responder_txd;
   endsequence
   sequence rec_edge_s;
      responder_txd && !stuck_hit;
   endsequence
   gpio_oe_follow_a: assert property ((pin8_func == llpc_pkg::FN_GPIO) |=> // RULE2
      pin8_oe == $past(port_a_bit_seven_dir)) else $error("gpio oe mismatch");
   input_gate_a: assert property (!pad_reg[5] |=> !port_a_bit_seven_in) // RULE4
      else $error("input path not gated");
   owner_port_b_a: assert property ((!lin_reg[0] && !port_b_bit_one_dir) |=> !lin_pin_oe) // RULE5
      else $error("port b oe not followed");
   hibernate_off_a: assert property ((hibernate && !lin_reg[llpc_pkg::POLICY_BIT] && lin_sync_reg[1]) // RULE6
      |=> !lin_tx_analog_on) else $error("tx analog on in hibernate");
   filter_locked_a: assert property ((wr && addr == llpc_pkg::RXF_S1_ADDR && !filter_write_unlock) // RULE8
      |=> $stable(rx_filter_stage_enables)) else $error("locked enables changed");
   stuck_set_a: assert property (stuck_hit |=> tx_stuck_flag) else $error("stuck flag not set"); // RULE12
   stuck_clear_a: assert property (dom_hold_s ##1 rec_edge_s |=> !tx_stuck_flag) // RULE13
      else $error("stuck flag not cleared");
   stuck_no_sw_a: assert property ((tx_stuck_flag && !responder_txd) |=> tx_stuck_flag) // RULE13
      else $error("stuck flag dropped while dominant");
   tx_disable_a: assert property ((tx_stuck_flag && lin_reg[llpc_pkg::OWNER_BIT]) |=> !lin_pin_oe && !lin_tx_analog_on) // RULE14
      else $error("transmitter not disabled");
   led_manual_a: assert property ((led_src_reg == 24'h000000) [*2] |-> // RULE17
      led_drive == $past(led_manual_drive_bits)) else $error("manual led mismatch");
   irq_clear_pulse_a: assert property ((irq_clr_reg && !(wr && addr == llpc_pkg::TX_IRQ_ADDR)) |=> !irq_clr_reg) // RULE21
      else $error("clear bit stuck");
endmodule

// [hw/llpc_pkg.sv]
// Constants and carrier types for the LIN, LED and pin control block
package llpc_pkg;
   // Register byte addresses
   localparam logic [31:0] PIN8_PAD_ADDR   = 32'h5001201c;
   localparam logic [31:0] LIN_PIN_ADDR    = 32'h50012024;
   localparam logic [31:0] RXF_S1_ADDR     = 32'h50012028;
   localparam logic [31:0] RXF_S23_ADDR    = 32'h5001202c;
   localparam logic [31:0] TX_MON_ADDR     = 32'h50012038;
   localparam logic [31:0] LED_SENSE_ADDR  = 32'h5001203c;
   localparam logic [31:0] LED_SRC_ADDR    = 32'h50012040;
   localparam logic [31:0] LED_MAN_ADDR    = 32'h50012044;
   localparam logic [31:0] LED_PU_ADDR     = 32'h50012048;
   localparam logic [31:0] PROBE_ONE_ADDR  = 32'h5001204c;
   localparam logic [31:0] TX_IRQ_ADDR     = 32'h50012058;
   localparam logic [31:0] FILT_KEY_ADDR   = 32'h5001205c;
   localparam logic [31:0] TRIM_KEY_ADDR   = 32'h50012064;
   // Writable masks and values after reset
   localparam logic [31:0] PIN8_PAD_MASK   = 32'h000003ff;
   localparam logic [31:0] PIN8_PAD_RST    = 32'h00000288;
   localparam logic [31:0] LED_SENSE_MASK  = 32'h00c78f00;
   localparam logic [31:0] LED_SENSE_RST   = 32'h00c00000;
   localparam logic [31:0] PROBE_ONE_MASK  = 32'h1fffff07;
   localparam logic [23:0] LED_RST         = 24'h000000;
   localparam logic [3:0]  RXF_EN_RST      = 4'hf;
   localparam logic [6:0]  S1_RISE_RST     = 7'h00;
   localparam logic [6:0]  S1_FALL_RST     = 7'h08;
   localparam logic [6:0]  S2_RISE_RST     = 7'h20;
   localparam logic [6:0]  S2_FALL_RST     = 7'h10;
   localparam logic [6:0]  S3_RISE_RST     = 7'h28;
   localparam logic [6:0]  S3_FALL_RST     = 7'h28;
   // Field positions
   localparam int POLICY_BIT    = 25;
   localparam int TXON_BIT      = 5;
   localparam int OWNER_BIT     = 0;
   localparam int RISE_LO_POS   = 16;
   localparam int FALL_LO_POS   = 8;
   localparam int S3_RISE_POS   = 24;
   localparam int S3_FALL_POS   = 16;
   localparam int S2_RISE_POS   = 8;
   localparam int S2_FALL_POS   = 0;
   localparam int FLAG_BIT      = 8;
   localparam int VFW_BIT       = 15;
   localparam int SENSE_BIT     = 8;
   localparam int UNLOCK_BIT    = 31;
   localparam int IRQ_ACT_BIT   = 24;
   localparam int IRQ_STS_BIT   = 16;
   localparam int IRQ_CLR_BIT   = 8;
   localparam int LED_CHANNELS  = 24;
   // Pin functions
   localparam logic [2:0] FN_GPIO  = 3'h0;
   localparam logic [2:0] FN_PWM   = 3'h1;
   localparam logic [2:0] FN_URX   = 3'h2;
   localparam logic [2:0] FN_USW   = 3'h3;
   localparam logic [2:0] FN_MOSI  = 3'h4;
   localparam logic [2:0] FN_FILT2 = 3'h5;
   // Timing
   localparam int CLK_PERIOD_NS     = 50;
   localparam int TX_STUCK_MS       = 64;
   localparam int TX_STUCK_CYC_DEF  = (TX_STUCK_MS * 1000000) / CLK_PERIOD_NS;
   localparam int STUCK_CNT_W       = 21;
   typedef struct packed {
      logic drive_strength_high;
      logic drive_strength_low;
      logic schmitt_on;
      logic slew_select;
      logic input_path_on;
      logic pulldown_on;
      logic pullup_off_n;
   } llpc_pad_t;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } llpc_bus_req_t;
endpackage

// [tb/llpc_lin_bus.sv]
// Far-side model of the LIN wire
`timescale 1ns/10ps
module llpc_lin_bus (
   input  wire logic lin_pin_out,
   input  wire logic lin_pin_oe,
   input  wire logic bus_dominant,
   output      logic lin_pin_in
);
   // Pull-up holds recessive unless a party pulls low
   assign lin_pin_in = !((lin_pin_oe && !lin_pin_out) || bus_dominant);
endmodule

// [tb/llpc_top_test.sv]
// Self-checking bench for the LIN, LED and pin control block
`timescale 1ns/10ps
module llpc_top_test;
   logic                    clock = 0;
   logic                    rst = 1;
   llpc_pkg::llpc_bus_req_t bus_req = '0;
   logic [31:0]             rdata, q[$];
   logic [23:0]             led_drive, led_pullup_bits, pwm_led = 0, led_fwd;
   logic [7:0]              rnd = 0, rnd_d = 0;
   logic                    rd_d = 0, txd = 1, dir = 0, hib = 0, fwd_on = 0;
   logic                    pin8_oe, lin_pin_in, lin_pin_out, lin_pin_oe, fwd_sense, analog_on;
   int                      err_count = 0, total_checks = 0;
   llpc_top #(.TX_STUCK_CYCLES(20)) i_llpc_top (.clock(clock), .rst(rst), .bus_req(bus_req), .rdata(rdata),
      .pin8_in(rnd[6]), .pin8_out(), .pin8_oe(pin8_oe), .pin8_pad(), .port_a_bit_seven_out(rnd[1]),
      .port_a_bit_seven_dir(dir), .port_a_bit_seven_in(), .pwm3_out(rnd[0]), .uart_txd(1'b1),
      .uart_tx_oe(1'b0), .uart_rxd(), .spi_mosi(rnd[2]), .lin_pin_in(lin_pin_in), .lin_pin_out(lin_pin_out),
      .lin_pin_oe(lin_pin_oe), .lin_tx_analog_on(analog_on), .hibernate(hib), .lin_sleep(1'b0),
      .port_b_bit_one_out(rnd[3]), .port_b_bit_one_dir(rnd[4]), .port_b_bit_one_in(), .responder_txd(txd),
      .responder_rxd(), .pwm_led(pwm_led), .led_drive(led_drive), .led_pullup_bits(led_pullup_bits),
      .led_forward_drive(led_fwd), .forward_sense_on(fwd_sense), .adc_ch2_active(rnd[5]),
      .channel_two_led_pick(rnd[7:3]));
   llpc_lin_bus i_llpc_lin_bus (.lin_pin_out(lin_pin_out), .lin_pin_oe(lin_pin_oe), .bus_dominant(1'b0),
      .lin_pin_in(lin_pin_in));
   initial begin
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      rnd  <= $urandom;
      rnd_d <= rnd;
      rd_d <= bus_req.rd;
   end
   // Read data stands in the cycle after the strobe
   always @(negedge clock) begin
      if (rd_d) begin
         check(rdata, q.pop_front(), "rdata");
      end
      if (fwd_on) begin
         check(led_fwd, (rnd_d[5] && rnd_d[7:3] < 5'h18) ? 24'h000001 << rnd_d[7:3] : 24'h000000,
               "led_forward_drive");
      end
   end
   task check(input logic [31:0] s, input logic [31:0] e, input string n);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge clock);
      bus_req <= '0;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      q.push_back(e);
      @(posedge clock);
      bus_req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clock);
      bus_req <= '0;
   endtask
   task finish_test;
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(32'h70439d54));
      repeat (10) @(posedge clock);
      rst <= 0;
      rd(llpc_pkg::PIN8_PAD_ADDR, 32'h00000288);
      rd(llpc_pkg::RXF_S1_ADDR, 32'h0000080f);
      rd(llpc_pkg::RXF_S23_ADDR, 32'h28282010);
      rd(llpc_pkg::TX_MON_ADDR, 32'h00000001);
      rd(32'h50012000, 32'h00000000);
      wr(llpc_pkg::RXF_S1_ADDR, 32'h00000800);
      rd(llpc_pkg::RXF_S1_ADDR, 32'h0000080f);
      wr(llpc_pkg::TRIM_KEY_ADDR, 32'h0000005a);
      wr(llpc_pkg::FILT_KEY_ADDR, 32'h80000000);
      wr(llpc_pkg::RXF_S1_ADDR, 32'h00000805);
      rd(llpc_pkg::RXF_S1_ADDR, 32'h00000805);
      pwm_led <= $urandom;
      wr(llpc_pkg::LED_MAN_ADDR, 32'h00a5c3e1);
      wr(llpc_pkg::LED_PU_ADDR, 32'h005a3c1e);
      repeat (2) @(posedge clock);
      check(led_drive, 24'ha5c3e1, "led_drive");
      check(led_pullup_bits, 24'h5a3c1e, "led_pullup_bits");
      wr(llpc_pkg::LED_SRC_ADDR, 32'h00ffffff);
      repeat (2) @(posedge clock);
      check(led_drive, pwm_led, "pwm led_drive");
      wr(llpc_pkg::LED_SENSE_ADDR, 32'h00c08100);
      @(posedge clock);
      fwd_on <= 1;
      repeat (800) @(posedge clock);
      check(fwd_sense, 1'b1, "forward_sense_on");
      dir <= 1;
      repeat (3) @(posedge clock);
      check(pin8_oe, 1'b1, "pin8_oe");
      wr(llpc_pkg::LIN_PIN_ADDR, 32'h00000021);
      repeat (3) @(posedge clock);
      check(lin_pin_oe, 1'b1, "lin_pin_oe");
      txd <= 0;
      repeat (30) @(posedge clock);
      check(lin_pin_oe, 1'b0, "stuck lin_pin_oe");
      wr(llpc_pkg::TX_MON_ADDR, 32'h00000001);
      rd(llpc_pkg::TX_MON_ADDR, 32'h00000101);
      rd(llpc_pkg::TX_IRQ_ADDR, 32'h00010000);
      wr(llpc_pkg::TX_IRQ_ADDR, 32'h00000100);
      rd(llpc_pkg::TX_IRQ_ADDR, 32'h00000000);
      txd <= 1;
      repeat (3) @(posedge clock);
      rd(llpc_pkg::TX_MON_ADDR, 32'h00000001);
      check(analog_on, 1'b1, "lin_tx_analog_on");
      hib <= 1;
      repeat (2) @(posedge clock);
      check(analog_on, 1'b0, "hibernate lin_tx_analog_on");
      wr(llpc_pkg::LIN_PIN_ADDR, 32'h02000021);
      repeat (2) @(posedge clock);
      check(analog_on, 1'b1, "policy lin_tx_analog_on");
      repeat (3) @(posedge clock);
      finish_test();
   end
   initial begin
      #(3000 * 50);
      err_count++;
      finish_test();
   end
endmodule
